// file: asm_status_mode.sv
// Status and operating-configuration register bank behind the three-wire serial port.
`timescale 1ns/1ps
module asm_status_mode
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Serial port, sampled on clk; sclk idles high.
   input  wire logic        cs_b,
   input  wire logic        sclk,
   input  wire logic        din,
   output logic             dout_rdy_b,
   // Conversion engine side.
   input  wire logic        conv_load,
   input  wire logic [23:0] conv_data,
   input  wire logic [3:0]  conv_channel,
   input  wire logic        conv_clamped,
   input  wire logic        pre_update,
   input  wire logic        power_down_or_idle,
   input  wire logic        sync_b,
   input  wire logic        ref_invalid,
   input  wire logic        reference_detect_enable,
   // Operating configuration fields.
   output logic [2:0]       operating_mode_select,
   output logic             append_status_enable,
   output logic [1:0]       clock_source_select,
   output logic             third_order_filter_select,
   output logic             parity_enable,
   output logic             single_cycle_enable,
   output logic             rejection_60hz_enable,
   output logic [9:0]       output_rate_divider,
   output logic             filter_restart,
   // Status view.
   output logic [7:0]       conversion_status,
   output logic [23:0]      held_result
);
   import asm_pkg::*;

   typedef struct packed
   {
      logic [23:0] mode;
      logic        rdy;
      logic        err;
      logic        missing_reference_flag;
      logic        par;
      logic [3:0]  chan;
      logic [23:0] result;
      asm_phase_e  phase;
      logic [2:0]  rs;
      logic        sclk_q;
      logic        dout;
      logic        restart;
   } asm_state_s;

   asm_state_s  s;
   asm_state_s  next_s;

   logic        rise;
   logic        fall;
   logic        sh_load;
   logic [31:0] sh_data;
   logic [5:0]  sh_len;
   logic        sh_shift;
   logic [31:0] sh_q;
   logic [5:0]  sh_cnt;
   logic        mode_wr;
   logic        data_rd;
   logic [7:0]  comm;
   logic [23:0] word;
   logic [23:0] stored;
   logic [7:0]  status_now;

   // Transfer length of each register; the data word grows by the status byte when appended.
   function automatic logic [5:0] reg_len(input logic [2:0] rs, input logic append);
      logic [5:0] len;
      len = LEN_WORD;
      case (rs)
         RS_STATUS, RS_ID, RS_GPO : len = LEN_BYTE;
         RS_DATA                  : len = append ? LEN_APPEND : LEN_WORD;
         default                  : len = LEN_WORD;
      endcase
      return len;
   endfunction

   // Word presented for a read, left aligned so the first bit leaves from the top.
   function automatic logic [31:0] read_word(input logic [2:0]  rs,
                                             input logic [23:0] mode,
                                             input logic [23:0] result,
                                             input logic [7:0]  status);
      logic [31:0] w;
      w = 32'h00000000;
      case (rs)
         RS_STATUS : w = {status, 24'h000000};
         RS_MODE   : w = {mode, 8'h00};
         RS_DATA   : w = {result, status};
         default   : w = 32'h00000000;
      endcase
      return w;
   endfunction

   // Serial edges seen on the system clock.
   assign rise       = sclk & ~s.sclk_q;
   assign fall       = ~sclk & s.sclk_q;
   assign status_now = {s.rdy, s.err, s.missing_reference_flag, s.par, s.chan};

   asm_shift u_shift
   (
      .clk       (clk),
      .rst_b     (rst_b),
      .load      (sh_load),
      .load_data (sh_data),
      .load_len  (sh_len),
      .shift     (sh_shift),
      .shift_in  (din),
      .shift_q   (sh_q),
      .count     (sh_cnt)
   );

   // Next-state logic: serial framing first, then the status flags that it affects.
   always_comb
   begin
      next_s         = s;
      sh_load        = 1'b0;
      sh_data        = 32'h00000000;
      sh_len         = LEN_BYTE;
      sh_shift       = 1'b0;
      mode_wr        = 1'b0;
      data_rd        = 1'b0;
      comm           = 8'h00;
      word           = 24'h000000;
      stored         = 24'h000000;
      next_s.sclk_q  = sclk;
      next_s.restart = 1'b0;

      // Deselecting the port abandons any partial transfer and rearms for a byte.
      if (cs_b)
      begin
         next_s.phase = PH_COMM;
         sh_load      = 1'b1;
         next_s.dout  = s.rdy;
      end
      else
      begin
         unique case (s.phase)
            PH_COMM:
            begin
               next_s.dout = s.rdy; // RULE4
               // A leading one is not taken, so an idle-high data line never frames a byte.
               if (rise && !(sh_cnt == LEN_BYTE && din))
               begin
                  sh_shift = 1'b1;
                  if (sh_cnt == LEN_LAST)
                  begin
                     comm      = {sh_q[6:0], din};
                     next_s.rs = comm[COMM_RS_HI:COMM_RS_LO];
                     sh_load   = 1'b1;
                     if (comm[COMM_RW])
                     begin
                        next_s.phase = PH_READ;
                        sh_len  = reg_len(comm[COMM_RS_HI:COMM_RS_LO], s.mode[MODE_DATSTA]);
                        sh_data = read_word(comm[COMM_RS_HI:COMM_RS_LO], s.mode, s.result,
                                            status_now); // RULE11
                     end
                     else if (comm[COMM_RS_HI:COMM_RS_LO] == RS_STATUS)
                     begin
                        // Code zero on a write addresses only the communication byte. RULE18
                        sh_len = LEN_BYTE;
                     end
                     else
                     begin
                        next_s.phase = PH_WRITE;
                        sh_len = reg_len(comm[COMM_RS_HI:COMM_RS_LO], 1'b0);
                     end
                  end
               end
            end
            PH_WRITE:
            begin
               next_s.dout = s.rdy;
               if (rise)
               begin
                  sh_shift = 1'b1;
                  if (sh_cnt == LEN_LAST)
                  begin
                     // First bit received ends up on top of the word. RULE15
                     word = {sh_q[22:0], din};
                     if (s.rs == RS_MODE) // RULE13
                     begin
                        next_s.mode = word & MODE_WR_MASK; // RULE14 RULE17 RULE19
                        mode_wr     = 1'b1;
                     end
                     next_s.phase = PH_COMM;
                     sh_load      = 1'b1;
                  end
               end
            end
            PH_READ:
            begin
               // Output moves on the falling edge so the host samples a stable bit. RULE15
               if (fall)
               begin
                  next_s.dout = sh_q[31];
               end
               if (rise)
               begin
                  sh_shift = 1'b1;
                  if (sh_cnt == LEN_LAST)
                  begin
                     data_rd      = (s.rs == RS_DATA);
                     next_s.phase = PH_COMM;
                     sh_load      = 1'b1;
                  end
               end
            end
            default:
            begin
               next_s.phase = PH_COMM;
               sh_load      = 1'b1;
            end
         endcase
      end

      // Reference watch runs every cycle, so the flag drops as soon as it recovers.
      next_s.missing_reference_flag = ref_invalid & reference_detect_enable; // RULE7 RULE8

      // Capture of a new result with its error, parity and channel.
      if (conv_load)
      begin
         stored        = s.missing_reference_flag ? 24'hFFFFFF : conv_data; // RULE7
         next_s.result = stored;
         next_s.chan   = conv_channel; // RULE12
         next_s.err    = conv_clamped | s.missing_reference_flag; // RULE5
         next_s.par    = s.mode[MODE_PARITY_ENABLE] & (^stored); // RULE10
      end

      // A configuration write starts a new conversion and clears the error.
      if (mode_wr)
      begin
         // A result landing in the same cycle keeps its error, so the set wins over the clear.
         if (!conv_load)
         begin
            next_s.err  = 1'b0; // RULE6
         end
         next_s.restart = 1'b1; // RULE16
      end

      // An invalid reference wins over any clear in the same cycle.
      if (ref_invalid)
      begin
         next_s.err = 1'b1; // RULE9
      end

      // New data clears ready; a read or an imminent overwrite sets it again.
      if (conv_load)
      begin
         next_s.rdy = 1'b0; // RULE1
      end
      else if (data_rd || pre_update)
      begin
         next_s.rdy = 1'b1; // RULE2
      end

      // Stopped or restarted conversion always reads as not ready.
      if (power_down_or_idle || !sync_b)
      begin
         next_s.rdy = 1'b1; // RULE3
      end
      if (mode_wr)
      begin
         next_s.rdy = 1'b1; // RULE16
      end
   end

   // State register with documented reset values.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         s        <= '0;
         s.mode   <= MODE_RESET; // RULE13
         s.rdy    <= STATUS_RESET[ST_RDY]; // RULE18
         s.err    <= STATUS_RESET[ST_ERR];
         s.missing_reference_flag  <= STATUS_RESET[ST_MISSING_REFERENCE_FLAG];
         s.par    <= STATUS_RESET[ST_PAR];
         s.chan   <= STATUS_RESET[3:0];
         s.sclk_q <= 1'b1;
         s.dout   <= 1'b1;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Outputs are flip-flop contents only.
   assign dout_rdy_b                = s.dout;
   assign operating_mode_select     = s.mode[MODE_MD_HI:MODE_MD_LO];
   assign append_status_enable      = s.mode[MODE_DATSTA];
   assign clock_source_select       = s.mode[MODE_CLK_HI:MODE_CLK_LO];
   assign third_order_filter_select = s.mode[MODE_THIRD_ORDER_FILTER_SELECT];
   assign parity_enable             = s.mode[MODE_PARITY_ENABLE];
   assign single_cycle_enable       = s.mode[MODE_SINGLE];
   assign rejection_60hz_enable     = s.mode[MODE_REJECTION_60HZ_ENABLE];
   assign output_rate_divider       = s.mode[MODE_FS_HI:MODE_FS_LO];
   assign filter_restart            = s.restart;
   assign conversion_status         = status_now;
   assign held_result               = s.result;
endmodule

// file: asm_pkg.sv
// Constants for the converter status and operating-configuration register bank.
// Operation
// RULE1: Ready flag clears when a fresh conversion result is stored.
// RULE2: Ready flag sets after a result read and before a pending overwrite.
// RULE3: Ready flag sets in power-down or idle, or while restart pin is low.
// RULE4: Serial-out pin shows conversion completion when no read is shifting.
// RULE5: Clamp error flag updates with each result, set for saturated results.
// RULE6: Clamp error flag clears on a host write that starts a conversion.
// RULE7: Missing reference flag follows the reference; results saturate to ones meanwhile.
// RULE8: Missing reference flag works only with reference detection enabled.
// RULE9: Clamp error flag also sets whenever the reference input is invalid.
// RULE10: With parity enabled, parity bit shows odd count of ones in result.
// RULE11: Host should enable status append when checking parity; status follows data.
// RULE12: Low status bits hold the channel of the stored result.
// RULE13: Configuration register uses select code 001 and resets to 0x080060.
// RULE14: Configuration register is 24 bits, readable and writable serially.
// RULE15: Configuration bits shift most significant first on reads and writes.
// RULE16: Any configuration write restarts modulator and filter, sets ready flag.
// RULE17: Configuration field layout fixed; bits 17, 16, 14 and 12 are zero.
// RULE18: Status register is 8-bit read-only, code 000 on reads, resets to 0x80.
// RULE19: Reserved configuration bits read as zero; host writes zero there.
package asm_pkg;

   // Register select codes.
   localparam logic [2:0]  RS_STATUS    = 3'h0;
   localparam logic [2:0]  RS_MODE      = 3'h1;
   localparam logic [2:0]  RS_CONFIG    = 3'h2;
   localparam logic [2:0]  RS_DATA      = 3'h3;
   localparam logic [2:0]  RS_ID        = 3'h4;
   localparam logic [2:0]  RS_GPO       = 3'h5;

   // Reset values.
   localparam logic [23:0] MODE_RESET   = 24'h080060;
   localparam logic [7:0]  STATUS_RESET = 8'h80;

   // Writable bits of the operating configuration; the others stay zero.
   localparam logic [23:0] MODE_WR_MASK = 24'hFCAFFF;

   // Operating configuration field positions.
   localparam int MODE_MD_HI  = 23;
   localparam int MODE_MD_LO  = 21;
   localparam int MODE_DATSTA = 20;
   localparam int MODE_CLK_HI = 19;
   localparam int MODE_CLK_LO = 18;
   localparam int MODE_THIRD_ORDER_FILTER_SELECT  = 15;
   localparam int MODE_PARITY_ENABLE  = 13;
   localparam int MODE_SINGLE = 11;
   localparam int MODE_REJECTION_60HZ_ENABLE  = 10;
   localparam int MODE_FS_HI  = 9;
   localparam int MODE_FS_LO  = 0;

   // Status field positions.
   localparam int ST_RDY   = 7;
   localparam int ST_ERR   = 6;
   localparam int ST_MISSING_REFERENCE_FLAG = 5;
   localparam int ST_PAR   = 4;

   // Communication byte field positions.
   localparam int COMM_WEN   = 7;
   localparam int COMM_RW    = 6;
   localparam int COMM_RS_HI = 5;
   localparam int COMM_RS_LO = 3;

   // Serial transfer lengths in bits.
   localparam logic [5:0]  LEN_BYTE   = 6'h08;
   localparam logic [5:0]  LEN_WORD   = 6'h18;
   localparam logic [5:0]  LEN_APPEND = 6'h20;
   localparam logic [5:0]  LEN_LAST   = 6'h01;

   // Serial phases.
   typedef enum logic [1:0]
   {
      PH_COMM  = 2'b00,
      PH_WRITE = 2'b01,
      PH_READ  = 2'b10
   } asm_phase_e;

endpackage

// file: asm_shift.sv
// Serial shift register with bit counter, used for both directions of the port.
`timescale 1ns/1ps
module asm_shift
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Control.
   input  wire logic        load,
   input  wire logic [31:0] load_data,
   input  wire logic [5:0]  load_len,
   input  wire logic        shift,
   input  wire logic        shift_in,
   // State.
   output logic      [31:0] shift_q,
   output logic      [5:0]  count
);
   import asm_pkg::*;

   typedef struct packed
   {
      logic [31:0] sr;
      logic [5:0]  cnt;
   } asm_shift_s;

   asm_shift_s s;
   asm_shift_s next_s;

   // Load takes priority so a frame boundary can reload in the same cycle as its last bit.
   always_comb
   begin
      next_s = s;
      if (load)
      begin
         next_s.sr  = load_data;
         next_s.cnt = load_len;
      end
      else if (shift)
      begin
         next_s.sr = {s.sr[30:0], shift_in};
         if (s.cnt != 6'h00)
         begin
            next_s.cnt = s.cnt - LEN_LAST;
         end
      end
   end

   // State register.
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         s <= '0;
         s.cnt <= LEN_BYTE;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign shift_q = s.sr;
   assign count   = s.cnt;
endmodule

// file: asm_status_mode_asserts.sv
// Concurrent checks on the status and operating-configuration register bank ports.
`timescale 1ns/1ps
module asm_status_mode_asserts
(
   // Clock and reset.
   input wire logic        clk,
   input wire logic        rst_b,
   // Serial port and conversion side.
   input wire logic        cs_b,
   input wire logic        dout_rdy_b,
   input wire logic        conv_load,
   input wire logic [3:0]  conv_channel,
   input wire logic        conv_clamped,
   input wire logic        pre_update,
   input wire logic        power_down_or_idle,
   input wire logic        sync_b,
   input wire logic        ref_invalid,
   input wire logic        reference_detect_enable,
   // Outputs watched.
   input wire logic        parity_enable,
   input wire logic        filter_restart,
   input wire logic [7:0]  conversion_status,
   input wire logic [23:0] held_result
);
   import asm_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // A load with nothing forcing ready must drop it, unless a write landed at the same edge.
   sequence plain_load;
      conv_load && !power_down_or_idle && sync_b;
   endsequence
   rdy_clear_load_a: assert property (plain_load |=> !conversion_status[ST_RDY] || filter_restart) else $error("ready not cleared by load");
   rdy_forced_a: assert property ((power_down_or_idle || !sync_b) |=> conversion_status[ST_RDY]) else $error("ready not forced");
   rdy_pre_update_a: assert property (pre_update && !conv_load |=> conversion_status[ST_RDY]) else $error("ready not set before update");
   restart_rdy_a: assert property (filter_restart |-> conversion_status[ST_RDY]) else $error("ready not set by config write");
   restart_err_a: assert property (filter_restart && !$past(ref_invalid) && !$past(conv_load) |-> !conversion_status[ST_ERR]) else $error("error not cleared");
   err_clamp_a: assert property (conv_load && conv_clamped |=> conversion_status[ST_ERR]) else $error("error not set on clamp");
   err_ref_a: assert property (ref_invalid |=> conversion_status[ST_ERR]) else $error("error not set on bad reference");
   missing_reference_flag_follow_a: assert property ($past(rst_b) |-> conversion_status[ST_MISSING_REFERENCE_FLAG] == $past(ref_invalid && reference_detect_enable)) else $error("missing_reference_flag flag wrong");
   chan_tag_a: assert property (conv_load |=> conversion_status[3:0] == $past(conv_channel)) else $error("channel tag wrong");
   parity_bit_a: assert property (conv_load |=> conversion_status[ST_PAR] == ($past(parity_enable) && ^held_result)) else $error("parity wrong");
   saturate_a: assert property (conv_load && conversion_status[ST_MISSING_REFERENCE_FLAG] |=> held_result == 24'hFFFFFF) else $error("result not saturated");
   idle_pin_a: assert property (cs_b && $past(cs_b) && $past(rst_b) |-> dout_rdy_b == $past(conversion_status[ST_RDY])) else $error("ready pin wrong");
endmodule

bind asm_status_mode asm_status_mode_asserts u_chk (.clk(clk), .rst_b(rst_b), .cs_b(cs_b),
   .dout_rdy_b(dout_rdy_b), .conv_load(conv_load), .conv_channel(conv_channel),
   .conv_clamped(conv_clamped), .pre_update(pre_update), .power_down_or_idle(power_down_or_idle),
   .sync_b(sync_b), .ref_invalid(ref_invalid), .reference_detect_enable(reference_detect_enable),
   .parity_enable(parity_enable), .filter_restart(filter_restart),
   .conversion_status(conversion_status), .held_result(held_result));

// file: asm_host_model.sv
// Host side of the three-wire serial port, shifting a command byte and data MSB first.
`timescale 1ns/1ps
module asm_host_model
(
   // Clock.
   input  wire logic clk,
   // Serial port.
   output logic      cs_b,
   output logic      sclk,
   output logic      din,
   input  wire logic dout_rdy_b
);
   // Idle levels at time zero: deselected, clock high.
   initial
   begin
      cs_b = 1'b1;
      sclk = 1'b1;
      din  = 1'b0;
   end

   // One whole transfer; sclk stays low for two clocks and high for three so every edge is seen.
   task automatic xfer(input logic [7:0] comm, input logic [31:0] wd, input int n,
                       output logic [31:0] rd);
      logic [39:0] sh;
      sh = {comm, wd << (32 - n)};
      rd = 32'h0;
      @(posedge clk);
      #1 cs_b = 1'b0;
      for (int i = 0; i < 8 + n; i++)
      begin
         @(posedge clk);
         #1 sclk = 1'b0;
         din = sh[39 - i];
         @(posedge clk);
         @(posedge clk);
         #1 if (i >= 8) rd = {rd[30:0], dout_rdy_b};
         sclk = 1'b1;
         @(posedge clk);
         @(posedge clk);
      end
      // Released line shows the inverse so a stale bit cannot pass unnoticed.
      #1 cs_b = 1'b1;
      din = ~din;
   endtask
endmodule

// file: testbench.sv
// Self-checking bench for the status and operating-configuration register bank.
`timescale 1ns/1ps
module testbench;
   import asm_pkg::*;
   logic clk, rst_b, cs_b, sclk, din, dout_rdy_b, conv_load, conv_clamped, pre_update;
   logic power_down_or_idle, sync_b, ref_invalid, reference_detect_enable;
   logic [23:0] conv_data, held_result;
   logic [3:0]  conv_channel;
   logic [2:0]  operating_mode_select;
   logic [1:0]  clock_source_select;
   logic [9:0]  output_rate_divider;
   logic [7:0]  conversion_status;
   logic        append_status_enable, third_order_filter_select, parity_enable;
   logic        single_cycle_enable, rejection_60hz_enable, filter_restart;
   logic [31:0] rdv;
   int          err_total, n_tests, cycles, restarts;

   asm_status_mode u_dut (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .din(din),
      .dout_rdy_b(dout_rdy_b), .conv_load(conv_load), .conv_data(conv_data),
      .conv_channel(conv_channel), .conv_clamped(conv_clamped), .pre_update(pre_update),
      .power_down_or_idle(power_down_or_idle), .sync_b(sync_b), .ref_invalid(ref_invalid),
      .reference_detect_enable(reference_detect_enable),
      .operating_mode_select(operating_mode_select), .append_status_enable(append_status_enable),
      .clock_source_select(clock_source_select),
      .third_order_filter_select(third_order_filter_select), .parity_enable(parity_enable),
      .single_cycle_enable(single_cycle_enable), .rejection_60hz_enable(rejection_60hz_enable),
      .output_rate_divider(output_rate_divider), .filter_restart(filter_restart),
      .conversion_status(conversion_status), .held_result(held_result));
   asm_host_model u_host (.clk(clk), .cs_b(cs_b), .sclk(sclk), .din(din),
      .dout_rdy_b(dout_rdy_b));

   // Free-running 100 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Cycle ceiling and restart pulse count; a hang is cut short as a failure.
   always @(posedge clk)
   begin
      cycles = cycles + 1;
      if (filter_restart === 1'b1) restarts = restarts + 1;
      if (cycles == 20000)
      begin
         err_total = err_total + 1;
         close_out();
      end
   end

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_cfg(input logic [23:0] d);
      u_host.xfer({2'b00, RS_MODE, 3'b000}, {8'h00, d}, 24, rdv);
   endtask

   task automatic rd_reg(input string what, input logic [2:0] rs, input int n,
                         input logic [31:0] exp);
      u_host.xfer({2'b01, rs, 3'b000}, 32'h0, n, rdv);
      chk(what, exp, rdv);
   endtask

   // One conversion result handed over for a single clock.
   task automatic load(input logic [23:0] d, input logic [3:0] ch, input logic cl);
      @(posedge clk);
      #1 conv_load = 1'b1;
      conv_data = d;
      conv_channel = ch;
      conv_clamped = cl;
      @(posedge clk);
      #1 conv_load = 1'b0;
   endtask

   initial
   begin
      {cycles, restarts, err_total, n_tests} = '0;
      {rst_b, conv_load, conv_clamped, pre_update, power_down_or_idle} = '0;
      {ref_invalid, reference_detect_enable, conv_data, conv_channel} = '0;
      sync_b = 1'b1;
      repeat (20) @(posedge clk);
      #1 rst_b = 1'b1;
      rd_reg("status reset", RS_STATUS, 8, 32'h80);
      rd_reg("config reset", RS_MODE, 24, 32'h080060);
      chk("clock source", 32'h2, clock_source_select);
      wr_cfg(24'hFCAFFF);
      rd_reg("config masked", RS_MODE, 24, 32'hFCAFFF);
      chk("fields", 32'h3FFF, {operating_mode_select, output_rate_divider, append_status_enable});
      chk("flags", 32'h3F, {clock_source_select, third_order_filter_select, parity_enable,
                            single_cycle_enable, rejection_60hz_enable});
      wr_cfg(24'h002000);
      load(24'h000007, 4'h9, 1'b0);
      @(posedge clk);
      #1 chk("ready pin", 32'h0, dout_rdy_b);
      rd_reg("status loaded", RS_STATUS, 8, 32'h19);
      wr_cfg(24'h102000);
      load(24'h800001, 4'h3, 1'b1);
      rd_reg("data appended", RS_DATA, 32, 32'h80000143);
      rd_reg("status after read", RS_STATUS, 8, 32'hC3);
      wr_cfg(24'h102000);
      rd_reg("status after write", RS_STATUS, 8, 32'h83);
      @(posedge clk);
      #1 {ref_invalid, reference_detect_enable} = 2'b11;
      repeat (2) @(posedge clk);
      load(24'h123456, 4'h5, 1'b0);
      chk("status missing_reference_flag", 32'h65, conversion_status);
      chk("saturated", 32'hFFFFFF, held_result);
      reference_detect_enable = 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("missing_reference_flag disabled", 32'h2, conversion_status[6:5]);
      ref_invalid = 1'b0;
      // Each forcing source in turn, after a load that dropped ready.
      for (int i = 0; i < 3; i++)
      begin
         load(24'h000001, 4'h1, 1'b0);
         {pre_update, power_down_or_idle, sync_b} = {i == 0, i == 1, i != 2};
         @(posedge clk);
         #1 {pre_update, power_down_or_idle, sync_b} = 3'b001;
         @(posedge clk);
         #1 chk("ready forced", 32'h1, conversion_status[ST_RDY]);
      end
      rd_reg("unmapped read", RS_ID, 8, 32'h0);
      chk("restart pulses", 32'h4, restarts);
      close_out();
   end
endmodule
